/* inc/sbc_map.vh */
`ifndef SBC_MAP_VH
`define SBC_MAP_VH
`define CLK_MHZ 10
`define WAKE_PULSE_US 10
`define WAKE_PULSE_CYC (`WAKE_PULSE_US * `CLK_MHZ)
`define RST_DUR_MS 15
`define RST_DUR_CYC (`RST_DUR_MS * 1000 * `CLK_MHZ)
`define WD_BASE_MS 10
`define WD_BASE_CYC (`WD_BASE_MS * 1000 * `CLK_MHZ)
`define MODE_NORMAL 2'h0
`define MODE_STANDBY 2'h1
`define MODE_STOP 2'h2
`define MODE_SLEEP 2'h3
`define REG_MODE 3'h0
`define REG_WATCHDOG_FAULT_OUT 3'h1
`define REG_INTCFG 3'h2
`define REG_FLAGS 3'h3
`define REG_IO 3'h4
`define WD_STYLE_BIT 0
`define WD_SEL_HI 2
`define WD_SEL_LO 1
`define WD_KICK_BIT 7
`define WD_FAULT_BIT 6
`define CAN_ON_BIT 4
`define FL_TEMP 0
`define FL_BWARN 1
`define FL_BFAIL 2
`define FL_WAKE 3
`define FRM_BITS 5'h10
`define FRM_HALF 5'h07
`define FRM_SAT 5'h1F
`define FRM_WR_BIT 15
`define FRM_A_HI 14
`define FRM_A_LO 12
`define SPI_A_HI 5
`define SPI_A_LO 3
`define SYNC_RST 14'h0004
`endif

/* design/sbc_core.v */
`timescale 1ns/1ns
`default_nettype none
`include "sbc_map.vh"

// Summary of operation
// - Sample serial input at clock falling edge
// - Update serial output after clock rising edge
// - Receive output low while bus dominant
// - Reset output low in reset mode or under-voltage
// - Regulator under-voltage forces reset output low
// - Interrupt low until software clears source
// - Only enabled sources drive the interrupt
// - Stop-mode wake gives one 10 us pulse
// - Serial port active only with select low
// - Watchdog fault output low on bad service
// - Window or time-out watchdog, register chosen
// - Watchdog failure pulls fault and reset low
// - Level inputs readable over serial port
// - Level inputs wake sleep and stop modes
// - Over-temperature warning flag and shutdown
// - Supply fail reported; supply warning only in normal and standby
// - Host writes pick the mode; wake, reset count, under-voltage and watchdog fault change it too
// - Transceiver enabled only by host writes; drives the bus only in normal mode
// - Reset held 15 ms after power-up
module sbc_core #(
    parameter RST_DUR_CYC = `RST_DUR_CYC,
    parameter WD_BASE_CYC = `WD_BASE_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Serial port pins
    input wire sclk,
    input wire mosi,
    input wire cs_n,
    output reg miso,
    output reg miso_en,
    // CAN pins
    input wire txd,
    input wire can_bus_dom,
    output reg rxd,
    output reg can_drive_dom,
    // Monitors and level inputs
    input wire vdd_uv,
    input wire temp_warn,
    input wire temp_shut,
    input wire battery_supply_fail,
    input wire battery_supply_warn,
    input wire [3:0] level_inputs,
    // Status outputs
    output reg reset_out_low_n,
    output reg int_n,
    output reg watchdog_fault_out_n,
    output reg vdd_reg_on
);

localparam ST_RESET = 3'h0;
localparam ST_NORMAL = 3'h1;
localparam ST_STANDBY = 3'h2;
localparam ST_STOP = 3'h3;
localparam ST_SLEEP = 3'h4;
// Full-width copies, cut on purpose to the counter widths
localparam [31:0] RST_LAST_W = RST_DUR_CYC - 1;
localparam [31:0] WD_BASE_W = WD_BASE_CYC;
localparam [31:0] PULSE_LEN_W = `WAKE_PULSE_CYC;
localparam [17:0] RST_LAST = RST_LAST_W[17:0];
localparam [19:0] WD_BASE = WD_BASE_W[19:0];
localparam [7:0] PULSE_LEN = PULSE_LEN_W[7:0];

reg [13:0] s1_r;
reg [13:0] s2_r;
reg sclk_d_r;
reg cs_d_r;
reg [13:0] edge_d_r;
reg [4:0] bit_cnt_r;
reg [15:0] in_sr_r;
reg [7:0] out_sr_r;
reg spi_pend_r;
reg [2:0] spi_idx_r;
reg [7:0] spi_dat_r;
reg [2:0] st_r;
reg [1:0] mode_req_r;
reg wd_style_r;
reg [1:0] wd_sel_r;
reg [19:0] wd_cnt_r;
reg [2:0] int_en_r;
reg [3:0] wake_en_r;
reg can_on_r;
reg [3:0] flags_r;
reg [17:0] rst_cnt_r;
reg [7:0] pulse_cnt_r;

// Pin inputs pass two flops before use
wire [13:0] async_in = {level_inputs, battery_supply_warn,
    battery_supply_fail, temp_shut, temp_warn, vdd_uv,
    can_bus_dom, txd, cs_n, mosi, sclk};

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        s1_r <= `SYNC_RST;
        s2_r <= `SYNC_RST;
    end else if (clk_en) begin
        s1_r <= async_in;
        s2_r <= s1_r;
    end
end

wire sclk_s = s2_r[0];
wire mosi_s = s2_r[1];
wire cs_s = s2_r[2];
wire txd_s = s2_r[3];
wire bus_s = s2_r[4];
wire uv_s = s2_r[5];
wire tw_s = s2_r[6];
wire ts_s = s2_r[7];
wire bf_s = s2_r[8];
wire bw_s = s2_r[9];
wire [3:0] lvl_s = s2_r[13:10];

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        sclk_d_r <= 1'b0;
        cs_d_r <= 1'b1;
        edge_d_r <= `SYNC_RST;
    end else if (clk_en) begin
        sclk_d_r <= sclk_s;
        cs_d_r <= cs_s;
        edge_d_r <= s2_r;
    end
end

wire sclk_rise = sclk_s & ~sclk_d_r;
wire sclk_fall = ~sclk_s & sclk_d_r;
wire cs_fall = ~cs_s & cs_d_r;
wire cs_rise = cs_s & ~cs_d_r;
wire [3:0] lvl_chg = lvl_s ^ edge_d_r[13:10];

// Register read values
wire running = (st_r == ST_NORMAL) | (st_r == ST_STANDBY);
wire wd_fault;
wire [7:0] rv_mode = {1'b0, st_r, 2'h0, mode_req_r};
wire [7:0] rv_watchdog_fault_out = {1'b0, ~watchdog_fault_out_n, 3'h0,
    wd_sel_r, wd_style_r};
wire [7:0] rv_int = {5'h00, int_en_r};
wire [7:0] rv_flags = {2'h0, uv_s, ts_s, flags_r};
wire [7:0] rv_wake = {4'h0, wake_en_r};

function [7:0] pick;
    input [2:0] idx;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    input [7:0] d;
    input [7:0] e;
    begin
        case (idx)
            `REG_MODE: pick = a;
            `REG_WATCHDOG_FAULT_OUT: pick = b;
            `REG_INTCFG: pick = c;
            `REG_FLAGS: pick = d;
            `REG_IO: pick = e;
            default: pick = 8'h00;
        endcase
    end
endfunction

wire [7:0] io_word = {lvl_s, 3'h0, can_on_r} | rv_wake;

// Serial slave
wire [2:0] spi_rd_idx = in_sr_r[`SPI_A_HI:`SPI_A_LO];
wire [7:0] spi_rd = pick(spi_rd_idx, rv_mode, rv_watchdog_fault_out,
    rv_int, rv_flags, io_word);

wire [2:0] apb_idx = paddr[4:2];
wire apb_ok = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0) &
    (apb_idx <= `REG_IO);
wire apb_wr = psel & penable & pready & pwrite & apb_ok;
wire spi_go = spi_pend_r & ~apb_wr;
wire wr_go = apb_wr | spi_go;
wire [2:0] wr_idx = apb_wr ? apb_idx : spi_idx_r;
wire [7:0] wr_dat = apb_wr ? pwdata[7:0] : spi_dat_r;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        bit_cnt_r <= 5'h00;
        in_sr_r <= 16'h0000;
        out_sr_r <= 8'h00;
        miso <= 1'b0;
        miso_en <= 1'b0;
        spi_pend_r <= 1'b0;
        spi_idx_r <= 3'h0;
        spi_dat_r <= 8'h00;
    end else if (clk_en) begin
        if (spi_go) begin
            spi_pend_r <= 1'b0;
        end
        if (cs_fall) begin
            bit_cnt_r <= 5'h00;
            in_sr_r <= 16'h0000;
            out_sr_r <= rv_flags;
            miso <= rv_flags[7];
            miso_en <= 1'b1;
        end else if (cs_rise) begin
            miso_en <= 1'b0;
            if (bit_cnt_r == `FRM_BITS && in_sr_r[`FRM_WR_BIT]) begin
                spi_pend_r <= 1'b1;
                spi_idx_r <= in_sr_r[`FRM_A_HI:`FRM_A_LO];
                spi_dat_r <= in_sr_r[7:0];
            end
        end else if (!cs_s) begin
            if (sclk_fall) begin
                in_sr_r <= {in_sr_r[14:0], mosi_s};
                if (bit_cnt_r != `FRM_SAT) begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
                if (bit_cnt_r == `FRM_HALF) begin
                    out_sr_r <= spi_rd;
                end
            end
            if (sclk_rise) begin
                miso <= out_sr_r[7];
                out_sr_r <= {out_sr_r[6:0], 1'b0};
            end
        end
    end
end

// APB answers after one wait state
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else if (clk_en) begin
        if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= ~apb_ok;
            prdata <= {24'h000000, pick(apb_idx, rv_mode,
                rv_watchdog_fault_out, rv_int, rv_flags, io_word)};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
end

// Control registers
wire mode_wr = wr_go & (wr_idx == `REG_MODE);
wire kick = wr_go & (wr_idx == `REG_WATCHDOG_FAULT_OUT) & wr_dat[`WD_KICK_BIT];
wire [3:0] fl_clr = (wr_go && wr_idx == `REG_FLAGS) ?
    wr_dat[3:0] : 4'h0;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        mode_req_r <= `MODE_NORMAL;
        wd_style_r <= 1'b0;
        wd_sel_r <= 2'h0;
        int_en_r <= 3'h0;
        wake_en_r <= 4'h0;
        can_on_r <= 1'b0;
    end else if (clk_en && wr_go) begin
        case (wr_idx)
            `REG_MODE: mode_req_r <= wr_dat[1:0];
            `REG_WATCHDOG_FAULT_OUT: begin
                wd_style_r <= wr_dat[`WD_STYLE_BIT];
                wd_sel_r <= wr_dat[`WD_SEL_HI:`WD_SEL_LO];
            end
            `REG_INTCFG: int_en_r <= wr_dat[2:0];
            `REG_IO: begin
                wake_en_r <= wr_dat[3:0];
                can_on_r <= wr_dat[`CAN_ON_BIT];
            end
            default: ;
        endcase
    end
end

// Event flags, set wins over clear
// enabled level changes wake
wire low_pwr = (st_r == ST_STOP) | (st_r == ST_SLEEP);
wire wake_ev = low_pwr & (|(lvl_chg & wake_en_r));
wire [3:0] ev;
assign ev[`FL_TEMP] = tw_s & ~edge_d_r[6];
assign ev[`FL_BWARN] = bw_s & ~edge_d_r[9] & running;
assign ev[`FL_BFAIL] = bf_s & ~edge_d_r[8];
assign ev[`FL_WAKE] = wake_ev;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        flags_r <= 4'h0;
    end else if (clk_en) begin
        flags_r <= (flags_r & ~fl_clr) | ev;
    end
end

// Watchdog, counts only when running
wire [19:0] wd_tmo = WD_BASE << wd_sel_r;
wire early = wd_style_r & (wd_cnt_r < (wd_tmo >> 1));
assign wd_fault = running & ((wd_cnt_r >= wd_tmo) | (kick & early));

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        wd_cnt_r <= 20'h00000;
        watchdog_fault_out_n <= 1'b1;
    end else if (clk_en) begin
        if (!running || kick || wd_fault) begin
            wd_cnt_r <= 20'h00000;
        end else begin
            wd_cnt_r <= wd_cnt_r + 20'h00001;
        end
        if (wd_fault) begin
            watchdog_fault_out_n <= 1'b0;
        end else if (kick) begin
            watchdog_fault_out_n <= 1'b1;
        end
    end
end

// Mode machine
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        st_r <= ST_RESET;
        rst_cnt_r <= 18'h00000;
        pulse_cnt_r <= 8'h00;
    end else if (clk_en) begin
        if (pulse_cnt_r != 8'h00) begin
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
        end
        if ((uv_s && st_r != ST_SLEEP) || wd_fault) begin
            st_r <= ST_RESET;
            rst_cnt_r <= 18'h00000;
        end else begin
            case (st_r)
                ST_RESET: begin
                    if (rst_cnt_r >= RST_LAST) begin
                        st_r <= ST_NORMAL;
                    end else begin
                        rst_cnt_r <= rst_cnt_r + 18'h00001;
                    end
                end
                ST_NORMAL, ST_STANDBY: begin
                    if (mode_wr) begin
                        case (wr_dat[1:0])
                            `MODE_NORMAL: st_r <= ST_NORMAL;
                            `MODE_STANDBY: st_r <= ST_STANDBY;
                            `MODE_STOP: st_r <= ST_STOP;
                            default: st_r <= ST_SLEEP;
                        endcase
                    end
                end
                ST_STOP: begin
                    if (wake_ev) begin
                        st_r <= ST_NORMAL;
                        pulse_cnt_r <= PULSE_LEN;
                    end
                end
                ST_SLEEP: begin
                    if (wake_ev) begin
                        st_r <= ST_RESET;
                        rst_cnt_r <= 18'h00000;
                    end
                end
                default: st_r <= ST_RESET;
            endcase
        end
    end
end

// Pin outputs
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        reset_out_low_n <= 1'b0;
        int_n <= 1'b1;
        vdd_reg_on <= 1'b1;
        rxd <= 1'b1;
        can_drive_dom <= 1'b0;
    end else if (clk_en) begin
        reset_out_low_n <= ~((st_r == ST_RESET) | uv_s);
        int_n <= ~(|(flags_r[2:0] & int_en_r)) &
            (pulse_cnt_r == 8'h00);
        vdd_reg_on <= ~ts_s & (st_r != ST_SLEEP);
        rxd <= ~bus_s;
        can_drive_dom <= can_on_r & (st_r == ST_NORMAL) & ~txd_s;
    end
end

endmodule
`default_nettype wire

/* verif/sbc_core_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module sbc_core_checker (
    // Clock and bus
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic cs_n,
    input wire logic miso_en,
    input wire logic txd,
    input wire logic can_bus_dom,
    input wire logic rxd,
    input wire logic can_drive_dom,
    input wire logic vdd_uv,
    input wire logic reset_out_low_n,
    input wire logic int_n,
    input wire logic watchdog_fault_out_n
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    property p_rx; $stable(can_bus_dom) [*5] |-> rxd == !can_bus_dom; endproperty
    a_rx: assert property (p_rx) else $error("rxd not inverse of bus");
    property p_uv; vdd_uv [*4] |-> !reset_out_low_n; endproperty
    a_uv: assert property (p_uv) else $error("reset out high in undervoltage");
    property p_desel; cs_n [*4] |-> !miso_en; endproperty
    a_desel: assert property (p_desel) else $error("miso driven while deselected");
    property p_sel; !cs_n [*5] |-> miso_en; endproperty
    a_sel: assert property (p_sel) else $error("miso not driven while selected");
    property p_tx; txd [*4] |-> !can_drive_dom; endproperty
    a_tx: assert property (p_tx) else $error("dominant drive with txd high");
    property p_wd; $fell(watchdog_fault_out_n) |-> ##[0:3] !reset_out_low_n; endproperty
    a_wd: assert property (p_wd) else $error("watchdog fault without reset");
    property p_rstcan; !reset_out_low_n [*4] |-> !can_drive_dom; endproperty
    a_rstcan: assert property (p_rstcan) else $error("bus driven in reset");
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("apb answer late");
    property p_err; pslverr |-> pready && psel && penable; endproperty
    a_err: assert property (p_err) else $error("pslverr outside access");
    c_wake: cover property ($fell(int_n));
    c_wd: cover property ($fell(watchdog_fault_out_n));
    c_rst: cover property ($rose(reset_out_low_n));
endmodule
bind sbc_core sbc_core_checker chk (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .miso_en(miso_en),
    .txd(txd), .can_bus_dom(can_bus_dom), .rxd(rxd), .can_drive_dom(can_drive_dom),
    .vdd_uv(vdd_uv), .reset_out_low_n(reset_out_low_n), .int_n(int_n),
    .watchdog_fault_out_n(watchdog_fault_out_n));
`default_nettype wire

/* verif/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic sclk,
    output logic mosi,
    output logic cs_n,
    input wire logic miso
);
    // Clock parked low outside frames
    initial begin
        sclk = 1'h0;
        mosi = 1'h0;
        cs_n = 1'h1;
    end
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(posedge mclk);
        cs_n <= 1'h0;
        for (int i = 15; i >= 0; i--) begin
            repeat (3) @(posedge mclk);
            mosi <= w[i];
            @(posedge mclk);
            sclk <= 1'h1;
            repeat (4) @(posedge mclk);
            sclk <= 1'h0;
            r[i] = miso;
        end
        repeat (4) @(posedge mclk);
        cs_n <= 1'h1;
        // Released line must not keep the last bit
        mosi <= ~w[0];
        repeat (250) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

/* verif/sbc_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sbc_map.vh"
module sbc_core_tb;
    typedef struct {
        logic [1:0] k;
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic er;
    } row_t;
    logic mclk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic txd = 1'h1, can_bus_dom = 1'h0, vdd_uv = 1'h0, temp_warn = 1'h0, temp_shut = 1'h0;
    logic bfail = 1'h0, bwarn = 1'h0;
    logic [3:0] lvl = 4'hB;
    logic [15:0] rx;
    wire [31:0] prdata;
    wire pready, pslverr, sclk, mosi, cs_n, miso, miso_en, rxd, can_drive_dom;
    wire reset_out_low_n, int_n, watchdog_fault_out_n, vdd_reg_on;
    // Undriven line shows the opposite of its last level
    wire miso_w = miso_en ? miso : !miso;
    int err_total = 0, comparisons = 0, n;
    // Kind 0 write, 1 read, 2 frame checked, 3 frame unchecked
    row_t rows[10] = '{
        '{2'h0, 16'h0010, 32'h1F, 32'h00, 1'h0}, '{2'h1, 16'h0010, 32'h00, 32'hBF, 1'h0},
        '{2'h1, 16'h0000, 32'h00, 32'h10, 1'h0}, '{2'h0, 16'h0014, 32'h55, 32'h00, 1'h1},
        '{2'h1, 16'h0002, 32'h00, 32'h10, 1'h1}, '{2'h3, 16'hA005, 32'h00, 32'h00, 1'h0},
        '{2'h1, 16'h0008, 32'h00, 32'h05, 1'h0}, '{2'h3, 16'h2007, 32'h00, 32'h00, 1'h0},
        '{2'h2, 16'h2000, 32'h00, 32'h05, 1'h0}, '{2'h2, 16'h4000, 32'h00, 32'hBF, 1'h0}};
    always #50 mclk = ~mclk;
    sbc_core #(.RST_DUR_CYC(50), .WD_BASE_CYC(2000)) uut (.mclk(mclk), .arst_n(arst_n),
        .clk_en(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
        .mosi(mosi), .cs_n(cs_n), .miso(miso), .miso_en(miso_en), .txd(txd),
        .can_bus_dom(can_bus_dom), .rxd(rxd), .can_drive_dom(can_drive_dom),
        .vdd_uv(vdd_uv), .temp_warn(temp_warn), .temp_shut(temp_shut),
        .battery_supply_fail(bfail), .battery_supply_warn(bwarn), .level_inputs(lvl),
        .reset_out_low_n(reset_out_low_n), .int_n(int_n),
        .watchdog_fault_out_n(watchdog_fault_out_n), .vdd_reg_on(vdd_reg_on));
    host_model hm (.mclk(mclk), .sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso_w));
    task automatic results;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic give_up;
        err_total++;
        results;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'h1) break;
        end
        if (i == 20) give_up;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        chk("reset_out_low_n", reset_out_low_n, 1'h0);
        chk("int_n", int_n, 1'h1);
        arst_n <= 1'h1;
        for (n = 0; n < 100 && reset_out_low_n !== 1'h1; n++) @(posedge mclk);
        chk("reset length", n >= 50 && n <= 56, 1'h1);
        apb(1'h1, 8'h04, 32'h86, rd, er);
        foreach (rows[i]) begin
            if (rows[i].k < 2'h2) begin
                apb(!rows[i].k[0], rows[i].a[7:0], rows[i].d, rd, er);
                if (rows[i].k == 2'h1) chk("prdata", rd, rows[i].e);
                chk("pslverr", er, rows[i].er);
            end else begin
                hm.xfer(rows[i].a, rx);
                if (rows[i].k == 2'h2) chk("miso byte", rx[7:0], rows[i].e);
            end
        end
        for (int i = 0; i < 4; i++) begin
            txd <= i[0];
            can_bus_dom <= i[1];
            repeat (5) @(posedge mclk);
            chk("rxd", rxd, !i[1]);
            chk("can_drive_dom", can_drive_dom, !i[0]);
        end
        apb(1'h1, 8'h10, 32'h0F, rd, er);
        repeat (5) @(posedge mclk);
        chk("can off", can_drive_dom, 1'h0);
        bwarn <= 1'h1;
        txd <= 1'h1;
        repeat (6) @(posedge mclk);
        chk("masked int", int_n, 1'h1);
        temp_warn <= 1'h1;
        repeat (6) @(posedge mclk);
        temp_warn <= 1'h0;
        repeat (6) @(posedge mclk);
        chk("int held", int_n, 1'h0);
        apb(1'h1, 8'h0C, 32'h0F, rd, er);
        repeat (3) @(posedge mclk);
        chk("int cleared", int_n, 1'h1);
        bfail <= 1'h1;
        repeat (6) @(posedge mclk);
        apb(1'h0, 8'h0C, 32'h00, rd, er);
        chk("supply fail", rd & 32'h07, 32'h04);
        // Clear sticky flags so the wake pulse stands alone
        apb(1'h1, 8'h0C, 32'h0F, rd, er);
        apb(1'h1, 8'h00, 32'h02, rd, er);
        repeat (4) @(posedge mclk);
        lvl <= 4'hA;
        for (n = 0; n < 20 && int_n !== 1'h0; n++) @(posedge mclk);
        if (n == 20) give_up;
        for (n = 0; n < 300 && int_n === 1'h0; n++) @(posedge mclk);
        chk("wake pulse", n, `WAKE_PULSE_CYC);
        repeat (200) @(posedge mclk);
        apb(1'h0, 8'h00, 32'h00, rd, er);
        chk("state after wake", rd & 32'h70, 32'h10);
        apb(1'h1, 8'h04, 32'h80, rd, er);
        for (n = 0; n < 2300 && watchdog_fault_out_n !== 1'h0; n++) @(posedge mclk);
        chk("timeout", n >= 1990 && n <= 2010, 1'h1);
        // Reset output follows the fault output one cycle later
        repeat (2) @(posedge mclk);
        chk("wd reset", reset_out_low_n, 1'h0);
        for (n = 0; n < 100 && reset_out_low_n !== 1'h1; n++) @(posedge mclk);
        if (n == 100) give_up;
        apb(1'h1, 8'h04, 32'h80, rd, er);
        repeat (3) @(posedge mclk);
        chk("good kick", watchdog_fault_out_n, 1'h1);
        apb(1'h1, 8'h04, 32'h01, rd, er);
        apb(1'h1, 8'h04, 32'h81, rd, er);
        repeat (4) @(posedge mclk);
        chk("early kick", watchdog_fault_out_n, 1'h0);
        for (n = 0; n < 100 && reset_out_low_n !== 1'h1; n++) @(posedge mclk);
        if (n == 100) give_up;
        apb(1'h1, 8'h04, 32'h06, rd, er);
        apb(1'h1, 8'h04, 32'h86, rd, er);
        vdd_uv <= 1'h1;
        repeat (6) @(posedge mclk);
        chk("uv reset", reset_out_low_n, 1'h0);
        vdd_uv <= 1'h0;
        temp_shut <= 1'h1;
        repeat (6) @(posedge mclk);
        chk("shutdown", vdd_reg_on, 1'h0);
        results;
    end
endmodule
`default_nettype wire
